// ===== logic/link_sync_pkg.sv
// shared constants, types and carriers for the link sync and frame alignment block
`default_nettype none

package link_sync_pkg;

  // ----------------------------------------------------------------
  // synchroniser and counter defaults
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam int FRAME_CYCLES = 2;
  localparam int FRAMES_PER_MULTI = 20;
  localparam int DIV_W = 2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam int FRAME_PHASE_RESET = 0;
  localparam int LMFC_PHASE_RESET = 0;
  // phase shown one cycle after a realigning edge
  localparam int FRAME_PHASE_AFTER_EDGE = 1;
  localparam logic [DIV_W-1:0] DIV_RESET = 2'h0;

  // ----------------------------------------------------------------
  // link states, gray along break, sync, wait, run
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_BREAK = 2'h0,
    LINK_SYNC = 2'h1,
    LINK_WAIT = 2'h3,
    LINK_RUN = 2'h2
  } linkState_t;

  // ----------------------------------------------------------------
  // configuration bits, all from logic on mclk
  // ----------------------------------------------------------------
  typedef struct packed {
    logic syncSourceSel;
    logic syncRequestReg_n;
    logic powerDown;
    logic sleepMode;
    logic [DIV_W-1:0] clockDivider;
    logic sysrefGateEnable;
  } cfg_t;

  // ----------------------------------------------------------------
  // reasons for a link break
  // ----------------------------------------------------------------
  typedef struct packed {
    logic powerDown;
    logic sleepMode;
    logic divChange;
    logic syncRequest;
    logic sysrefMisalign;
    logic clockLoss;
  } breakCause_t;

endpackage

`default_nettype wire

// ===== logic/sync_stages.sv
// multi-stage level synchroniser for inputs from outside mclk
`default_nettype none

module sync_stages #(
  parameter int STAGES = 2,
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // level in and out
  input wire logic asyncIn,
  output logic syncOut
);

  logic [STAGES-1:0] stage_q;

  initial begin
    if (STAGES < 2) begin
      $error("sync_stages needs at least two stages");
    end
  end

  // first stage feeds only the next stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage_q <= {STAGES{RESET_VAL}};
    end else begin
      stage_q <= {stage_q[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = stage_q[STAGES-1];

endmodule

`default_nettype wire

// ===== logic/frame_lmfc_counter.sv
// frame and local multi-frame phase counters
`default_nettype none

module frame_lmfc_counter #(
  parameter int FRAME_CYCLES = 2,
  parameter int FRAMES_PER_MULTI = 20,
  localparam int FW = (FRAME_CYCLES > 1) ? $clog2(FRAME_CYCLES) : 1,
  localparam int LW = (FRAMES_PER_MULTI > 1) ? $clog2(FRAMES_PER_MULTI) : 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic restart,
  input wire logic realign,
  input wire logic hold,
  // phase and ticks
  output logic [FW-1:0] framePhase_q,
  output logic [LW-1:0] lmfcPhase_q,
  output logic frameTick_q,
  output logic lmfcTick_q
);
  import link_sync_pkg::*;

  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);
  localparam logic [LW-1:0] LMFC_LAST = LW'(FRAMES_PER_MULTI - 1);

  logic [FW-1:0] frame_d;
  logic [LW-1:0] lmfc_d;

  initial begin
    if (FRAME_CYCLES < 2 || FRAMES_PER_MULTI < 2) begin
      $error("frame_lmfc_counter needs at least two cycles per frame and frames per multi-frame");
    end
  end

  always_comb begin
    frame_d = framePhase_q;
    lmfc_d = lmfcPhase_q;
    if (restart) begin
      frame_d = FW'(FRAME_PHASE_RESET);
      lmfc_d = LW'(LMFC_PHASE_RESET);
    end else if (realign) begin
      // the edge cycle counts as phase zero
      frame_d = FW'(FRAME_PHASE_AFTER_EDGE);
      lmfc_d = LW'(LMFC_PHASE_RESET);
    end else if (!hold) begin
      if (framePhase_q == FRAME_LAST) begin
        frame_d = '0;
        lmfc_d = (lmfcPhase_q == LMFC_LAST) ? '0 : lmfcPhase_q + 1'b1;
      end else begin
        frame_d = framePhase_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      framePhase_q <= FW'(FRAME_PHASE_RESET);
      lmfcPhase_q <= LW'(LMFC_PHASE_RESET);
      frameTick_q <= 1'b0;
      lmfcTick_q <= 1'b0;
    end else begin
      framePhase_q <= frame_d;
      lmfcPhase_q <= lmfc_d;
      frameTick_q <= (frame_d == '0);
      lmfcTick_q <= (frame_d == '0) && (lmfc_d == '0);
    end
  end

endmodule

`default_nettype wire

// ===== logic/link_sync_frame_alignment.sv
// link synchronisation, frame and multi-frame alignment, and link break control
//
// What this block does
// - low sync request level asks for resynchronisation
// - sync request pin taken fully asynchronous
// - source select one uses register request, ignores pin
// - counters start at default phase after reset
// - power-down or sleep breaks the link
// - clock divider change breaks the link
// - sync request from the selected source breaks link
// - misaligned sysref edge breaks link and realigns
// - aligned sysref edge keeps phase and link
// - sample clock interruption breaks the link
// - gate enabled while sysref high acts as edge
// - periodic sysref aligns once, later aligned edges ignored
`default_nettype none

module link_sync_frame_alignment #(
  parameter int SYNC_STAGES = link_sync_pkg::SYNC_STAGES,
  parameter int FRAME_CYCLES = link_sync_pkg::FRAME_CYCLES,
  parameter int FRAMES_PER_MULTI = link_sync_pkg::FRAMES_PER_MULTI,
  localparam int FW = (FRAME_CYCLES > 1) ? $clog2(FRAME_CYCLES) : 1,
  localparam int LW = (FRAMES_PER_MULTI > 1) ? $clog2(FRAMES_PER_MULTI) : 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins from outside mclk
  input wire logic syncRequest_n,
  input wire logic sysrefIn,
  input wire logic sampleClockInAlive,
  // configuration from logic on mclk
  input wire link_sync_pkg::cfg_t cfg,
  // link state
  output logic linkUp_q,
  output logic linkBreak_q,
  output link_sync_pkg::breakCause_t breakCause_q,
  output link_sync_pkg::linkState_t state_q,
  // alignment
  output logic realignPulse_q,
  output logic alignedOnce_q,
  output logic frameTick_q,
  output logic lmfcTick_q,
  output logic [FW-1:0] framePhase_q,
  output logic [LW-1:0] lmfcPhase_q
);
  import link_sync_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (SYNC_STAGES < 2) begin
      $error("link_sync_frame_alignment needs two or more synchroniser stages");
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic syncPinSync_n;
  logic sysrefSync;
  logic clockAliveSync;

  // idle high so that reset never looks like a request
  sync_stages #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_syncPin (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(syncRequest_n),
    .syncOut(syncPinSync_n)
  );

  sync_stages #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sysref (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(sysrefIn),
    .syncOut(sysrefSync)
  );

  // clock detector output; low means the sample clock has stopped
  sync_stages #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_clkAlive (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(sampleClockInAlive),
    .syncOut(clockAliveSync)
  );

  // ----------------------------------------------------------------
  // sync request source
  // ----------------------------------------------------------------
  logic syncReq;

  // pin is ignored entirely with register source, so it may float
  assign syncReq = cfg.syncSourceSel ? !cfg.syncRequestReg_n : !syncPinSync_n;

  // ----------------------------------------------------------------
  // divider change watch
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] divPrev_q;
  logic divValid_q;
  logic divChange;

  // previous value caught after reset release, never under reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      divPrev_q <= DIV_RESET;
      divValid_q <= 1'b0;
    end else begin
      divPrev_q <= cfg.clockDivider;
      divValid_q <= 1'b1;
    end
  end

  assign divChange = divValid_q && (divPrev_q != cfg.clockDivider);

  // ----------------------------------------------------------------
  // sysref gate and edge compare
  // ----------------------------------------------------------------
  logic sysrefGated;
  logic gatedPrev_q;
  logic sysrefEdge;
  logic phaseZero;
  logic alignedEdge;
  logic misEdge;

  // gate enable while high reads as an edge, by design of the gate
  assign sysrefGated = sysrefSync && cfg.sysrefGateEnable;
  assign sysrefEdge = sysrefGated && !gatedPrev_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gatedPrev_q <= 1'b0;
    end else begin
      gatedPrev_q <= sysrefGated;
    end
  end

  assign phaseZero = (framePhase_q == '0) && (lmfcPhase_q == '0);
  // before any edge the default phase is not trusted
  assign alignedEdge = sysrefEdge && alignedOnce_q && phaseZero;
  assign misEdge = sysrefEdge && !alignedEdge;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      alignedOnce_q <= 1'b0;
      realignPulse_q <= 1'b0;
    end else begin
      if (sysrefEdge) begin
        alignedOnce_q <= 1'b1;
      end
      realignPulse_q <= misEdge;
    end
  end

  // ----------------------------------------------------------------
  // frame and multi-frame counters
  // ----------------------------------------------------------------
  logic counterRestart;
  logic counterHold;

  // internal clocks stop while powered down or without sample clock
  assign counterHold = cfg.powerDown || cfg.sleepMode || !clockAliveSync;
  assign counterRestart = divChange;

  frame_lmfc_counter #(.FRAME_CYCLES(FRAME_CYCLES), .FRAMES_PER_MULTI(FRAMES_PER_MULTI)) u_counter (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(counterRestart),
    .realign(misEdge),
    .hold(counterHold),
    .framePhase_q(framePhase_q),
    .lmfcPhase_q(lmfcPhase_q),
    .frameTick_q(frameTick_q),
    .lmfcTick_q(lmfcTick_q)
  );

  // ----------------------------------------------------------------
  // break causes
  // ----------------------------------------------------------------
  breakCause_t cause_d;
  logic hardBreak;

  always_comb begin
    cause_d.powerDown = cfg.powerDown;
    cause_d.sleepMode = cfg.sleepMode;
    cause_d.divChange = divChange;
    cause_d.syncRequest = syncReq;
    cause_d.sysrefMisalign = misEdge;
    cause_d.clockLoss = !clockAliveSync;
  end

  assign hardBreak = cause_d.powerDown || cause_d.sleepMode || cause_d.divChange || cause_d.sysrefMisalign ||
                     cause_d.clockLoss;

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  linkState_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      LINK_BREAK: begin
        if (!hardBreak && syncReq) begin
          state_d = LINK_SYNC;
        end
      end
      LINK_SYNC: begin
        if (hardBreak) begin
          state_d = LINK_BREAK;
        end else if (!syncReq) begin
          state_d = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (hardBreak) begin
          state_d = LINK_BREAK;
        end else if (syncReq) begin
          state_d = LINK_SYNC;
        end else if (lmfcTick_q) begin
          // data starts on a multi-frame boundary
          state_d = LINK_RUN;
        end
      end
      LINK_RUN: begin
        if (hardBreak) begin
          state_d = LINK_BREAK;
        end else if (syncReq) begin
          state_d = LINK_SYNC;
        end
      end
      default: begin
        state_d = LINK_BREAK;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= LINK_BREAK;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      linkUp_q <= 1'b0;
      linkBreak_q <= 1'b0;
      breakCause_q <= '0;
    end else begin
      linkUp_q <= (state_d == LINK_RUN);
      linkBreak_q <= (state_q == LINK_RUN) && (state_d != LINK_RUN);
      breakCause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  pinSyncDelay_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(syncPinSync_n) |-> $past(syncRequest_n, SYNC_STAGES) == 1'b0)
    else $error("pin request reached logic without passing the synchroniser");

  syncBreak_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == LINK_RUN && syncReq && !hardBreak) |=> (!linkUp_q && linkBreak_q && state_q == LINK_SYNC))
    else $error("sync request did not break the running link");

  regSource_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg.syncSourceSel && cfg.syncRequestReg_n && state_q == LINK_RUN && !hardBreak) |=> linkUp_q)
    else $error("pin request acted while register source selected");

  powerBreak_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg.powerDown || cfg.sleepMode) |=> (!linkUp_q && state_q == LINK_BREAK))
    else $error("power-down or sleep left the link up");

  divBreak_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (divValid_q && $changed(cfg.clockDivider)) |=> (!linkUp_q && framePhase_q == '0 && lmfcPhase_q == '0))
    else $error("divider change did not break link and restart phase");

  clockLoss_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(clockAliveSync) |=> (!linkUp_q && $stable(framePhase_q)))
    else $error("sample clock loss left the link up or clocks running");

  misRealign_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (misEdge && !counterRestart) |=> (realignPulse_q && !linkUp_q && framePhase_q == FW'(FRAME_PHASE_AFTER_EDGE)
      && lmfcPhase_q == '0))
    else $error("misaligned sysref edge did not realign and break");

  alignedKeep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (alignedEdge && state_q == LINK_RUN && !hardBreak && !syncReq) |=> (linkUp_q && !realignPulse_q && !linkBreak_q))
    else $error("aligned sysref edge disturbed the link");

  gateEdge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($rose(cfg.sysrefGateEnable) && sysrefSync) |-> sysrefEdge ##1 alignedOnce_q)
    else $error("gate enable with sysref high was not taken as an edge");

  periodicOnce_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (sysrefEdge && alignedOnce_q && phaseZero) |=> !realignPulse_q)
    else $error("repeat aligned edge caused realignment");

  defaultPhase_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> (framePhase_q == '0 && lmfcPhase_q == '0 && !alignedOnce_q && !linkUp_q))
    else $error("counters did not start at default phase");

endmodule

`default_nettype wire

// ===== test/rx_sync_model.sv
// receiver-side model that raises and releases the sync request pin
`default_nettype none

module rx_sync_model #(
  parameter int LMFC_CYCLES = 40
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bench command and pin to the device
  input wire logic wantSync,
  output logic syncRequest_n
);
  int rxCount_q;
  logic holdLow_q;

  // ----------------------------------------------------------------
  // own multi-frame counter at the device's rate
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) rxCount_q <= 0;
    else rxCount_q <= (rxCount_q == LMFC_CYCLES - 1) ? 0 : rxCount_q + 1;
  end

  // release waits for own boundary, so bring-up time varies
  always_ff @(posedge mclk) begin
    if (!rst_n) holdLow_q <= 1'b0;
    else holdLow_q <= wantSync | (holdLow_q & (rxCount_q != 0));
  end

  assign syncRequest_n = !(wantSync | holdLow_q);
endmodule

`default_nettype wire

// ===== test/link_sync_frame_alignment_test.sv
// self-checking bench for the link sync and frame alignment block
`default_nettype none

module link_sync_frame_alignment_test;
  timeunit 1ns;
  timeprecision 100ps;
  import link_sync_pkg::*;

  localparam int LMFC = FRAME_CYCLES * FRAMES_PER_MULTI;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sysrefIn = 1'b0;
  logic sampleClockInAlive = 1'b1;
  logic wantSync = 1'b0;
  logic syncRequest_n;
  cfg_t cfg;
  logic linkUp_q;
  logic linkBreak_q;
  logic realignPulse_q;
  logic alignedOnce_q;
  logic frameTick_q;
  logic lmfcTick_q;
  breakCause_t breakCause_q;
  linkState_t state_q;
  logic [$clog2(FRAME_CYCLES)-1:0] framePhase_q;
  logic [$clog2(FRAMES_PER_MULTI)-1:0] lmfcPhase_q;
  int errTotal = 0;
  int checkCount = 0;
  int cyc = 0;
  int realigns = 0;
  int riseRef = 0;

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  always @(posedge mclk) if (realignPulse_q === 1'b1) realigns++;

  rx_sync_model #(.LMFC_CYCLES(LMFC)) partner (.mclk(mclk), .rst_n(rst_n), .wantSync(wantSync),
    .syncRequest_n(syncRequest_n));

  link_sync_frame_alignment uut (.mclk(mclk), .rst_n(rst_n), .syncRequest_n(syncRequest_n),
    .sysrefIn(sysrefIn), .sampleClockInAlive(sampleClockInAlive), .cfg(cfg), .linkUp_q(linkUp_q),
    .linkBreak_q(linkBreak_q), .breakCause_q(breakCause_q), .state_q(state_q),
    .realignPulse_q(realignPulse_q), .alignedOnce_q(alignedOnce_q), .frameTick_q(frameTick_q), .lmfcTick_q(lmfcTick_q),
    .framePhase_q(framePhase_q), .lmfcPhase_q(lmfcPhase_q));

  // ----------------------------------------------------------------
  // compare, wait and verdict
  // ----------------------------------------------------------------
  task automatic stopTest();
    $display("checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chkVec(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp);
    checkCount++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic sel(input int k);
    case (k)
      0: return linkUp_q;
      1: return linkBreak_q;
      3: return lmfcTick_q;
      4: return frameTick_q;
      default: return realignPulse_q;
    endcase
  endfunction

  // bounded wait; n counts the edges it took
  task automatic waitSel(input int k, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (sel(k) !== 1'b1 && n < lim);
    if (sel(k) !== 1'b1) begin
      errTotal++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      stopTest();
    end
  endtask

  function automatic logic [5:0] expCause(input int k);
    case (k)
      0: return 6'h20;
      1: return 6'h10;
      2: return 6'h08;
      3: return 6'h01;
      default: return 6'h04;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // stimulus helpers
  // ----------------------------------------------------------------
  task automatic bringUp();
    int n;
    @(posedge mclk);
    wantSync <= 1'b1;
    repeat (4) @(posedge mclk);
    wantSync <= 1'b0;
    waitSel(0, 4 * LMFC, n);
    chkVec({6'h0, state_q}, {6'h0, LINK_RUN});
  endtask

  // rise at a chosen offset from the last reference edge
  task automatic sysrefRise(input int phase);
    do @(posedge mclk); while ((cyc - riseRef) % LMFC != phase);
    sysrefIn <= 1'b1;
    riseRef = cyc;
  endtask

  task automatic sysrefFall();
    repeat (8) @(posedge mclk);
    sysrefIn <= 1'b0;
  endtask

  task automatic breakBy(input int k);
    int n;
    bringUp();
    @(posedge mclk);
    case (k)
      0: cfg.powerDown <= 1'b1;
      1: cfg.sleepMode <= 1'b1;
      2: cfg.clockDivider <= cfg.clockDivider ^ 2'($urandom_range(1, 3));
      3: sampleClockInAlive <= 1'b0;
      4: begin
        cfg.syncSourceSel <= 1'b1;
        cfg.syncRequestReg_n <= 1'b0;
      end
      default: wantSync <= 1'b1;
    endcase
    waitSel(1, 6, n);
    chkVec(8'(n), 8'((k == 3 || k == 5) ? SYNC_STAGES + 1 : 1));
    chkVec({2'h0, breakCause_q}, {2'h0, expCause(k)});
    chkBit(linkUp_q, 1'b0);
    @(posedge mclk);
    cfg <= '{syncSourceSel: 1'b0, syncRequestReg_n: 1'b1, powerDown: 1'b0, sleepMode: 1'b0,
      clockDivider: cfg.clockDivider, sysrefGateEnable: 1'b0};
    sampleClockInAlive <= 1'b1;
    wantSync <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int pre;
    int k;
    cfg = '0;
    cfg.syncRequestReg_n = 1'b1;
    void'($urandom(32'hf6b7));
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chkVec({6'h0, state_q}, {6'h0, LINK_BREAK});
    chkVec(8'(lmfcPhase_q), 8'h00);
    chkBit(alignedOnce_q, 1'b0);
    // first edge is never trusted, so it realigns
    @(posedge mclk);
    cfg.sysrefGateEnable <= 1'b1;
    sysrefRise(0);
    waitSel(2, 8, n);
    chkVec(8'(n), 8'(SYNC_STAGES + 1));
    chkVec(8'(framePhase_q), 8'(FRAME_PHASE_AFTER_EDGE));
    chkVec(8'(lmfcPhase_q), 8'h00);
    chkBit(alignedOnce_q, 1'b1);
    sysrefFall();
    bringUp();
    // tick spacing must equal the receiver's frame and multi-frame periods
    waitSel(3, LMFC + 1, n);
    waitSel(3, LMFC + 1, n);
    chkVec(8'(n), 8'(LMFC));
    waitSel(4, FRAME_CYCLES + 1, n);
    waitSel(4, FRAME_CYCLES + 1, n);
    chkVec(8'(n), 8'(FRAME_CYCLES));
    pre = realigns;
    repeat (2) begin
      repeat ($urandom_range(0, 50)) @(posedge mclk);
      sysrefRise(0);
      sysrefFall();
    end
    repeat (4) @(posedge mclk);
    #1;
    chkVec(8'(realigns - pre), 8'h00);
    chkBit(linkUp_q, 1'b1);
    sysrefRise($urandom_range(1, LMFC - 1));
    waitSel(2, 8, n);
    chkVec(8'(n), 8'(SYNC_STAGES + 1));
    chkVec(8'(framePhase_q), 8'(FRAME_PHASE_AFTER_EDGE));
    chkBit(linkUp_q, 1'b0);
    chkBit(linkBreak_q, 1'b1);
    chkVec({2'h0, breakCause_q}, 8'h02);
    sysrefFall();
    cfg.sysrefGateEnable <= 1'b0;
    repeat (4) @(posedge mclk);
    sysrefIn <= 1'b1;
    repeat (4) @(posedge mclk);
    pre = realigns;
    cfg.sysrefGateEnable <= 1'b1;
    waitSel(2, 4, n);
    @(posedge mclk);
    sysrefIn <= 1'b0;
    repeat (5) @(posedge mclk);
    sysrefIn <= 1'b1;
    waitSel(2, 8, n);
    @(posedge mclk);
    #1;
    chkVec(8'(realigns - pre), 8'h02);
    sysrefFall();
    cfg.sysrefGateEnable <= 1'b0;
    // pin is ignored while the register source is selected
    bringUp();
    @(posedge mclk);
    cfg.syncSourceSel <= 1'b1;
    wantSync <= 1'b1;
    repeat (10) @(posedge mclk);
    wantSync <= 1'b0;
    #1;
    chkBit(linkUp_q, 1'b1);
    repeat (2 * LMFC) @(posedge mclk);
    cfg.syncSourceSel <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      k = (i < 6) ? i : $urandom_range(0, 5);
      breakBy(k);
    end
    stopTest();
  end
endmodule

`default_nettype wire
